/* File: src/pafm_pkg.sv */
package pafm_pkg;

  // Output-capable pads, in the order of the pad vectors.
  localparam int NUM_PINS = 6;
  localparam int PIN_P7_0 = 0;
  localparam int PIN_P6_0 = 1;
  localparam int PIN_P6_1 = 2;
  localparam int PIN_P2_0 = 3;
  localparam int PIN_P2_1 = 4;
  localparam int PIN_P2_2 = 5;

  // Selections that exist per pad, one nibble per pad, pad 0 lowest.
  localparam logic [23:0] PIN_VALID = 24'h33_1fb7;

  // Pin io control register layout.
  localparam int SEL_MSB = 3;
  localparam int SEL_ENABLE_BIT = 3;
  localparam int GPIO_OUT_BIT = 4;
  localparam logic [7:0] IOCTL_RESET = 8'h00;

  // Register byte offsets.
  localparam logic [7:0] OFS_IOCTL_BASE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_PAD_LEVEL = 8'h1c;
  localparam logic [7:0] OFS_PORT5_LEVEL = 8'h20;

  // Status register fields.
  localparam int ST_TEST_MODE = 0;
  localparam int ST_DEBUG_ACTIVE = 1;
  localparam int ST_DEBUG_RESET = 2;
  localparam int ST_PULLDOWN = 3;
  localparam int ST_CAPTURED = 4;

  // Synchroniser vector layout.
  localparam int SYNC_W = 29;
  localparam int SY_PAD = 0;
  localparam int SY_P5 = 6;
  localparam int SY_P15 = 22;
  localparam int SY_FACTORY_TEST_STRAP = 27;
  localparam int SY_TRST = 28;
  localparam logic [1:0] SYNC_DEPTH = 2'd2;

  // Debug access positions that enable the data line pull-down.
  localparam logic [1:0] DAP_POS_0 = 2'd0;
  localparam logic [1:0] DAP_POS_2 = 2'd2;

  // AHB-Lite transfer codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic timer3_toggle_out;
    logic timer6_toggle_out;
    logic analog_mux_ctrl0;
    logic analog_mux_ctrl1;
    logic debug_break_out;
    logic serial1_ch1_data_out;
    logic can0_transmit;
    logic can1_transmit;
    logic tdo_data;
    logic tdo_oe;
  } pafm_periph_out_t;

  typedef struct packed {
    logic converter_request_gate_in;
    logic serial1_ch1_data_in;
    logic can0_receive_c;
    logic timer5_count_gate_in;
    logic jtag_tdi;
    logic jtag_tms;
    logic timer3_updown_in;
    logic t12_run_control_in;
    logic t13_run_control_in;
    logic serial2_ch0_data_in;
    logic debug_break_in;
    logic serial2_ch1_data_in;
    logic timer6_count_gate_in;
  } pafm_in_fn_t;

endpackage

/* File: src/pafm_top.sv */
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// [RULE_01] Select field 1x00 picks output zero, upward.
// [RULE_02] Hardware-controlled output overrides the select field.
// [RULE_03] Board holds test strap high normally.
// [RULE_04] Board holds debug reset input high normally.
// [RULE_05] Debug reset strap sampled at reset release.
// [RULE_06] Board pulses debug reset low once afterward.
// [RULE_07] Data line pull-down for access positions 0/2.
// [RULE_08] Port 7.0: timer3 toggle, timer6 toggle.
// [RULE_09] Port 6.0: mux bit0, break out, gate in.
// [RULE_10] Port 6.1: mux bit1, timer3, serial data.
// [RULE_11] Port 2.1/2.2 drive CAN transmit lines.
// [RULE_12] Ports 15 and 5 are input only, shared.
// [RULE_13] Port 5.2/5.4 feed JTAG and timer3 inputs.
// [RULE_14] Port 5.10 feeds break input, serial input.
// [RULE_15] Port 2.0 feeds CAN receive, timer5 input.
// [RULE_16] Port 5.8 feeds both run-control inputs.
// [RULE_17] Inputs always observe the synchronized pad level.
module pafm_top (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Peripheral side.
  input wire pafm_pkg::pafm_periph_out_t periph_out,
  input wire logic [1:0] dap_position,
  output pafm_pkg::pafm_in_fn_t in_fn,
  output logic test_mode,
  output logic debug_active,
  output logic debug_sys_rst,
  // Pads.
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe,
  output logic tdo_pulldown_en,
  input wire logic [15:0] port5_in,
  input wire logic [4:0] port15_in,
  input wire logic factory_test_strap,
  input wire logic debug_reset_strap
);

  logic [7:0] ioctl_q [6];
  logic [28:0] sync1_q;
  logic [28:0] sync2_q;
  logic [1:0] cnt_q;
  logic captured_q;
  logic debug_active_q;
  logic debug_sys_rst_q;
  logic pulldown_q;
  logic test_mode_q;
  logic [5:0] pad_out_q;
  logic [5:0] pad_oe_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [3:0] alt [6];
  logic [5:0] pad_out_d;
  logic [5:0] pad_oe_d;

  wire [28:0] raw_in = {debug_reset_strap, factory_test_strap, port15_in, port5_in, pad_in};
  wire [15:0] p5 = sync2_q[pafm_pkg::SY_P5 +: 16];
  wire [4:0] p15 = sync2_q[pafm_pkg::SY_P15 +: 5];
  wire [5:0] pads = sync2_q[pafm_pkg::SY_PAD +: 6];
  wire trst_s = sync2_q[pafm_pkg::SY_TRST];
  wire hw_tdo = debug_active_q & periph_out.tdo_oe;
  wire take = hsel & hready & (htrans == pafm_pkg::HTRANS_NONSEQ);
  wire take_wr = take & hwrite;
  wire take_rd = take & ~hwrite;
  wire [5:0] rd_idx = haddr[7:2];
  wire is_ioctl = rd_idx < 6'(pafm_pkg::NUM_PINS);
  wire [2:0] rd_pin = rd_idx[2:0];
  wire [5:0] wr_idx = wr_addr_q[7:2];
  wire [2:0] wr_pin = wr_idx[2:0];
  wire wr_ioctl = wr_pend_q & (wr_idx < 6'(pafm_pkg::NUM_PINS));
  wire start_done = cnt_q == pafm_pkg::SYNC_DEPTH;
  wire dap_pd = (dap_position == pafm_pkg::DAP_POS_0) | (dap_position == pafm_pkg::DAP_POS_2);

  // Status word shows the block's own state.
  wire [31:0] status_w = {27'h000_0000, captured_q, pulldown_q, debug_sys_rst_q,
                          debug_active_q, test_mode_q};
  wire [31:0] rdata_w =
    is_ioctl ? {24'h00_0000, ioctl_q[rd_pin]} :
    (haddr == pafm_pkg::OFS_STATUS) ? status_w :
    (haddr == pafm_pkg::OFS_PAD_LEVEL) ? {21'h00_0000, p15, pads} :
    (haddr == pafm_pkg::OFS_PORT5_LEVEL) ? {16'h0000, p5} : 32'h0000_0000;

  // Alternate output sources per pad, index is the selection number.
  assign alt[pafm_pkg::PIN_P7_0] = {1'b0, periph_out.timer6_toggle_out,
    periph_out.timer3_toggle_out, ioctl_q[0][pafm_pkg::GPIO_OUT_BIT]}; // see [RULE_08]
  assign alt[pafm_pkg::PIN_P6_0] = {periph_out.debug_break_out, 1'b0,
    periph_out.analog_mux_ctrl0, ioctl_q[1][pafm_pkg::GPIO_OUT_BIT]}; // see [RULE_09]
  assign alt[pafm_pkg::PIN_P6_1] = {periph_out.serial1_ch1_data_out,
    periph_out.timer3_toggle_out, periph_out.analog_mux_ctrl1,
    ioctl_q[2][pafm_pkg::GPIO_OUT_BIT]}; // see [RULE_10]
  assign alt[pafm_pkg::PIN_P2_0] = {3'b000, ioctl_q[3][pafm_pkg::GPIO_OUT_BIT]}; // see [RULE_15]
  assign alt[pafm_pkg::PIN_P2_1] = {2'b00, periph_out.can0_transmit,
    ioctl_q[4][pafm_pkg::GPIO_OUT_BIT]}; // see [RULE_11]
  assign alt[pafm_pkg::PIN_P2_2] = {2'b00, periph_out.can1_transmit,
    ioctl_q[5][pafm_pkg::GPIO_OUT_BIT]}; // see [RULE_11]

  // Each pad drives when bit 3 is set and the selection exists; bit 2 is ignored.
  for (genvar p = 0; p < 6; p++) begin : g_pin
    wire [1:0] sel = ioctl_q[p][1:0];
    wire sel_on = ioctl_q[p][pafm_pkg::SEL_ENABLE_BIT] & pafm_pkg::PIN_VALID[4 * p + int'(sel)];
    if (p == pafm_pkg::PIN_P7_0) begin : g_hw
      assign pad_oe_d[p] = hw_tdo | sel_on; // see [RULE_02]
      assign pad_out_d[p] = hw_tdo ? periph_out.tdo_data : (sel_on & alt[p][sel]); // see [RULE_02]
    end else begin : g_sw
      assign pad_oe_d[p] = sel_on; // see [RULE_01]
      assign pad_out_d[p] = sel_on & alt[p][sel]; // see [RULE_01]
    end
  end

  // Input functions fan out from the synchronized pad levels at all times.
  assign in_fn.converter_request_gate_in = pads[pafm_pkg::PIN_P6_0]; // see [RULE_09] [RULE_17]
  assign in_fn.serial1_ch1_data_in = pads[pafm_pkg::PIN_P6_0]; // see [RULE_17]
  assign in_fn.can0_receive_c = pads[pafm_pkg::PIN_P2_0]; // see [RULE_15]
  assign in_fn.timer5_count_gate_in = pads[pafm_pkg::PIN_P2_0]; // see [RULE_15]
  assign in_fn.jtag_tdi = p5[2]; // see [RULE_13] [RULE_12]
  assign in_fn.jtag_tms = p5[4]; // see [RULE_13]
  assign in_fn.timer3_updown_in = p5[4]; // see [RULE_13]
  assign in_fn.t12_run_control_in = p5[8]; // see [RULE_16]
  assign in_fn.t13_run_control_in = p5[8]; // see [RULE_16]
  assign in_fn.serial2_ch0_data_in = p5[8]; // see [RULE_16]
  assign in_fn.debug_break_in = p5[10]; // see [RULE_14]
  assign in_fn.serial2_ch1_data_in = p5[10]; // see [RULE_14]
  assign in_fn.timer6_count_gate_in = p15[4]; // see [RULE_12]

  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign tdo_pulldown_en = pulldown_q;
  assign test_mode = test_mode_q;
  assign debug_active = debug_active_q;
  assign debug_sys_rst = debug_sys_rst_q;
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Two-stage synchroniser for every pin level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q; // see [RULE_17]
    end
  end

  // The debug reset strap and access position are taken once the synchroniser holds a real pin level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      captured_q <= 1'b0;
      debug_active_q <= 1'b0;
      pulldown_q <= 1'b0;
    end else if (ce && !captured_q) begin
      cnt_q <= cnt_q + 2'd1;
      if (start_done) begin
        captured_q <= 1'b1;
        debug_active_q <= trst_s; // see [RULE_05]
        pulldown_q <= dap_pd; // see [RULE_07]
      end
    end
  end

  // Debug system is held in reset while the strap input is low after activation.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_sys_rst_q <= 1'b0;
      test_mode_q <= 1'b0;
    end else if (ce) begin
      debug_sys_rst_q <= debug_active_q & ~trst_s; // see [RULE_06] [RULE_04]
      test_mode_q <= ~sync2_q[pafm_pkg::SY_FACTORY_TEST_STRAP]; // see [RULE_03]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
    end else if (ce) begin
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  // Bus slave: read data is sampled in the address phase, writes land in the data phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_q <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else if (ce) begin
      wr_pend_q <= take_wr;
      wr_addr_q <= haddr;
      if (take_rd) begin
        hrdata_q <= rdata_w;
      end
    end
  end

  for (genvar r = 0; r < 6; r++) begin : g_reg
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ioctl_q[r] <= pafm_pkg::IOCTL_RESET;
      end else if (ce && wr_ioctl && wr_pin == 3'(r)) begin
        ioctl_q[r] <= {3'b000, hwdata[4:0]};
      end
    end
  end

  property p_sel_gpio;
    @(posedge clk) disable iff (rst)
    ce && ioctl_q[3][3] && ioctl_q[3][1:0] == 2'd0
      |=> pad_oe_q[3] && pad_out_q[3] == $past(ioctl_q[3][4]);
  endproperty
  a_sel_gpio: assert property (p_sel_gpio) else $error("gpio selection not driven"); // see [RULE_01]

  property p_sel_off;
    @(posedge clk) disable iff (rst)
    ce && !ioctl_q[4][3] |=> !pad_oe_q[4];
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("pad driven while select off"); // see [RULE_01]

  property p_hw_tdo;
    @(posedge clk) disable iff (rst)
    ce && debug_active_q && periph_out.tdo_oe
      |=> pad_oe_q[0] && pad_out_q[0] == $past(periph_out.tdo_data);
  endproperty
  a_hw_tdo: assert property (p_hw_tdo) else $error("debug data not on pad"); // see [RULE_02]

  property p_p70_t6;
    @(posedge clk) disable iff (rst)
    ce && !hw_tdo && ioctl_q[0][3] && ioctl_q[0][1:0] == 2'd2
      |=> pad_out_q[0] == $past(periph_out.timer6_toggle_out);
  endproperty
  a_p70_t6: assert property (p_p70_t6) else $error("timer6 toggle not routed"); // see [RULE_08]

  property p_p60_brk;
    @(posedge clk) disable iff (rst)
    ce && ioctl_q[1][3] && ioctl_q[1][1:0] == 2'd3
      |=> pad_oe_q[1] && pad_out_q[1] == $past(periph_out.debug_break_out);
  endproperty
  a_p60_brk: assert property (p_p60_brk) else $error("break output not routed"); // see [RULE_09]

  property p_p61_ser;
    @(posedge clk) disable iff (rst)
    ce && ioctl_q[2][3] && ioctl_q[2][1:0] == 2'd3
      |=> pad_out_q[2] == $past(periph_out.serial1_ch1_data_out);
  endproperty
  a_p61_ser: assert property (p_p61_ser) else $error("serial data not routed"); // see [RULE_10]

  property p_p22_can;
    @(posedge clk) disable iff (rst)
    ce && ioctl_q[5][3] && ioctl_q[5][1:0] == 2'd1
      |=> pad_oe_q[5] && pad_out_q[5] == $past(periph_out.can1_transmit);
  endproperty
  a_p22_can: assert property (p_p22_can) else $error("CAN1 transmit not routed"); // see [RULE_11]

  property p_strap;
    @(posedge clk) disable iff (rst)
    $rose(captured_q) |-> debug_active_q == $past(trst_s) && $past(cnt_q) == 2'd2;
  endproperty
  a_strap: assert property (p_strap) else $error("debug strap captured wrong"); // see [RULE_05]

  property p_pulldown;
    @(posedge clk) disable iff (rst)
    $rose(captured_q) |-> pulldown_q == ($past(dap_position) inside {2'd0, 2'd2});
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down enable wrong"); // see [RULE_07]

  property p_tdi_fan;
    @(posedge clk) disable iff (rst)
    ce && $past(ce) && !$past(rst) |=> in_fn.jtag_tdi == $past(port5_in[2], 2);
  endproperty
  a_tdi_fan: assert property (p_tdi_fan) else $error("TDI level lags wrong"); // see [RULE_13]

  property p_brk_fan;
    @(posedge clk) disable iff (rst)
    ce && $past(ce) && !$past(rst) |=> in_fn.debug_break_in == $past(port5_in[10], 2);
  endproperty
  a_brk_fan: assert property (p_brk_fan) else $error("break input level wrong"); // see [RULE_14]

  property p_run_fan;
    @(posedge clk) disable iff (rst)
    ce && $past(ce) && !$past(rst) |=> in_fn.t12_run_control_in == $past(port5_in[8], 2)
      && in_fn.t13_run_control_in == $past(port5_in[8], 2);
  endproperty
  a_run_fan: assert property (p_run_fan) else $error("run control level wrong"); // see [RULE_16]

  property p_can_rx;
    @(posedge clk) disable iff (rst)
    ce && $past(ce) && !$past(rst) |=> in_fn.can0_receive_c == $past(pad_in[3], 2);
  endproperty
  a_can_rx: assert property (p_can_rx) else $error("CAN receive level wrong"); // see [RULE_15] [RULE_17]

endmodule // pafm_top

/* File: sim/pafm_board.sv */
`timescale 1ns/10ps
// Board side of the pins: strap levels, input-only pins and the pad wiring.
module pafm_board (
  // Design pads.
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic tdo_pulldown_en,
  // Board settings.
  input wire logic [5:0] ext_pads,
  input wire logic [15:0] p5,
  input wire logic [4:0] p15,
  input wire logic factory_test_strap_lvl,
  input wire logic trst_lvl,
  // Pin levels seen by the design.
  output logic [5:0] pad_in,
  output logic [15:0] port5_in,
  output logic [4:0] port15_in,
  output logic factory_test_strap,
  output logic debug_reset_strap
);
  // An undriven data line is pulled low while the pull-down is on.
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_pads & ~{5'h00, tdo_pulldown_en});
  assign port5_in = p5;
  assign port15_in = p15;
  assign factory_test_strap = factory_test_strap_lvl;
  assign debug_reset_strap = trst_lvl;
endmodule // pafm_board

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("Error %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
  logic clk, rst, hwrite, hreadyout, hresp, test_mode, debug_active, debug_sys_rst;
  logic tdo_pulldown_en, fts, drs, factory_test_strap_lvl, trst_lvl;
  logic [1:0] htrans, dap_position;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, rdata;
  logic [5:0] pad_in, pad_out, pad_oe, ext_pads, e;
  logic [15:0] port5_in, p5;
  logic [4:0] port15_in, p15, d;
  pafm_pkg::pafm_periph_out_t periph_out;
  pafm_pkg::pafm_in_fn_t in_fn;
  int fails, check_count;

  pafm_top pafm_top_i (.clk(clk), .rst(rst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph_out(periph_out),
    .dap_position(dap_position), .in_fn(in_fn), .test_mode(test_mode),
    .debug_active(debug_active), .debug_sys_rst(debug_sys_rst), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .tdo_pulldown_en(tdo_pulldown_en),
    .port5_in(port5_in), .port15_in(port15_in), .factory_test_strap(fts),
    .debug_reset_strap(drs));
  pafm_board pafm_board_i (.pad_out(pad_out), .pad_oe(pad_oe),
    .tdo_pulldown_en(tdo_pulldown_en), .ext_pads(ext_pads), .p5(p5), .p15(p15),
    .factory_test_strap_lvl(factory_test_strap_lvl), .trst_lvl(trst_lvl), .pad_in(pad_in), .port5_in(port5_in),
    .port15_in(port15_in), .factory_test_strap(fts), .debug_reset_strap(drs));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // One single AHB-Lite transfer; read data lands in rdata.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    haddr <= a;
    hwrite <= w;
    htrans <= pafm_pkg::HTRANS_NONSEQ;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 200);
    rdata = hrdata;
    if (n >= 200) fails++;
  endtask

  // Expected {oe, out} of one pad for selection index i = pad * 4 + sel.
  function automatic logic [1:0] sel_exp(int i, logic g, pafm_pkg::pafm_periph_out_t f);
    logic [23:0] s;
    s = {2'b00, f.can1_transmit, g, 2'b00, f.can0_transmit, g, 3'b000, g,
      f.serial1_ch1_data_out, f.timer3_toggle_out, f.analog_mux_ctrl1, g,
      f.debug_break_out, 1'b0, f.analog_mux_ctrl0, g,
      1'b0, f.timer6_toggle_out, f.timer3_toggle_out, g};
    sel_exp = {pafm_pkg::PIN_VALID[i], pafm_pkg::PIN_VALID[i] & s[i]};
  endfunction

  initial begin
    #800000;
    fails++;
    end_of_test();
  end

  initial begin
    rst = 1'b1; htrans = 2'h0; haddr = 8'h00; hwrite = 1'b0; hwdata = 32'h0000_0000;
    periph_out = '0; dap_position = 2'd2; ext_pads = 6'h00; p5 = 16'h0000; p15 = 5'h00;
    factory_test_strap_lvl = 1'b1; trst_lvl = 1'b1; fails = 0; check_count = 0;
    do_reset();
    bus(pafm_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK(rdata, 32'h0000_001a)
    `CHK({debug_active, tdo_pulldown_en, test_mode}, 3'b110)
    `CHK(hresp, 1'b0)
    bus(8'h00, 1'b0, 32'h0);
    `CHK(rdata, 32'h0000_0000)
    for (int p = 0; p < 6; p++) begin
      for (int k = 0; k < 2; k++) begin
        for (int s = 0; s < 4; s++) begin
          periph_out <= k ? 10'h154 : 10'h2aa;
          d = {k[0], 1'b1, s[0], s[1:0]};
          bus(8'(p * 4), 1'b1, {27'h0, d});
          repeat (2) @(posedge clk);
          `CHK({pad_oe[p], pad_out[p]}, sel_exp(p * 4 + s, d[4], periph_out))
          bus(8'(p * 4), 1'b0, 32'h0);
          `CHK(rdata, {27'h0, d})
        end
      end
      bus(8'(p * 4), 1'b1, 32'h0);
    end
    $display("Test select table done");
    periph_out <= 10'h003;
    repeat (2) @(posedge clk);
    `CHK({pad_oe[0], pad_out[0]}, 2'b11)
    periph_out <= 10'h002;
    bus(8'h04, 1'b1, 32'h0000_0011);
    repeat (2) @(posedge clk);
    `CHK({pad_oe[1], pad_oe[0]}, 2'b00)
    bus(8'h04, 1'b1, 32'h0);
    $display("Test override done");
    for (int k = 0; k < 2; k++) begin
      ext_pads <= k ? 6'h2a : 6'h15;
      p5 <= k ? 16'haaaa : 16'h5555;
      p15 <= k ? 5'h15 : 5'h0a;
      repeat (4) @(posedge clk);
      e = ext_pads & 6'h3e;
      `CHK(in_fn, {e[1], e[1], e[3], e[3], p5[2], p5[4], p5[4], p5[8], p5[8], p5[8], p5[10], p5[10], p15[4]})
      bus(pafm_pkg::OFS_PAD_LEVEL, 1'b0, 32'h0);
      `CHK(rdata, {21'h0, p15, e})
      bus(pafm_pkg::OFS_PORT5_LEVEL, 1'b0, 32'h0);
      `CHK(rdata, {16'h0, p5})
      bus(8'h40, 1'b0, 32'h0);
      `CHK(rdata, 32'h0000_0000)
    end
    $display("Test inputs done");
    trst_lvl <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(debug_sys_rst, 1'b1)
    bus(pafm_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK(rdata, 32'h0000_001e)
    factory_test_strap_lvl <= 1'b0;
    dap_position <= 2'd1;
    do_reset();
    bus(pafm_pkg::OFS_STATUS, 1'b0, 32'h0);
    `CHK(rdata, 32'h0000_0011)
    `CHK({test_mode, debug_active, tdo_pulldown_en}, 3'b100)
    $display("Test straps done");
    end_of_test();
  end
endmodule // tb_top
